// ---- token_bus_consts.vh ----
/*
 * constants of the token bus data exchange block: register offsets, field positions,
 * reset values and timing counts.
 * assumes a 25 MHz clock and an APB master with 32-bit data and byte addresses.
 */
// Behaviour
// R1: only sources with a nonzero configured length reach the CPU buffer.
// R2: received data is buffered; the CPU reads data and status from the buffer.
// R3: lost source with OFF default reads back as all zeros.
// R4: lost source with HOLD default reads back its last valid data; the code reads the live buffer, which a wrong-length message also overwrites.
// R5: 32-bit presence vector, bit n belongs to bus address n.
// R6: present correctly configured sources read 1; own bit reads 1 while working.
// R7: silent, unconfigured or misconfigured sources read 0 and get the default.
// R8: presence vector sits at a fixed register, fresh on every read.
// R9: a source that signs off without data gets the default but keeps its bit.
// R10: output data is held until the token, then sent per device in address order.
// R11: outgoing global data is held until the token, then broadcast.
// R12: with the CPU stopped no global or output data is sent.
// R13: token walks addresses 0 to 31, idle addresses skipped after a short wait.
// R14: incoming messages are accepted at all times, token or not.
// R15: transmit only with the token; end the turn with a broadcast sign-off.
// R16: once configured, the presence vector is always delivered.
// R17: a token rotation lasts no less than the minimum scan period.
// R18: one global block per scan each way, at most 128 bytes.
// R19: only the latest CPU contents are sent at the token.
// R20: a source silent for a whole rotation counts as lost.
`ifndef TOKEN_BUS_CONSTS_VH
`define TOKEN_BUS_CONSTS_VH
// register offsets and regions
`define OFS_CTRL 14'h0000
`define OFS_STATUS 14'h0004
`define OFS_TOKEN 14'h0008
`define OFS_LEN_BASE 14'h0100
`define RGN_LEN 5'h02
`define RGN_RX 2'h1
`define RGN_OUT 2'h2
`define RGN_GTX 2'h3
// control fields
`define CTRL_RUN 0
`define CTRL_HOLD 1
`define CTRL_CFG 2
`define CTRL_OWN_LO 8
`define CTRL_OWN_HI 12
`define CTRL_GLEN_LO 16
`define CTRL_GLEN_HI 23
`define CTRL_RESET 32'h00000000
// length register fields
`define LEN_RX_LO 0
`define LEN_RX_HI 7
`define LEN_OUT_LO 8
`define LEN_OUT_HI 15
`define BLOCK_MAX 8'h80
// timing
`define CLK_MHZ 25
`define CLK_NS 40
`define MIN_ROT_US 3000
`define MIN_ROT_CYC (`MIN_ROT_US * `CLK_MHZ)
`define SKIP_NS 26000
`define SKIP_CYC ((`SKIP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- token_tracker.v ----
/*
 * follows the bus token from address 0 to 31 and back to 0.
 * assumes bus events arrive on the same clock, one per cycle at most.
 */
`default_nettype none
`include "token_bus_consts.vh"
module token_tracker (
	// clock and reset
	input wire clock,
	input wire srst,
	// configuration
	input wire enable,
	input wire [4:0] own_addr,
	// bus events
	input wire rx_valid,
	input wire rx_signoff,
	input wire [4:0] rx_src,
	input wire own_done,
	// token state
	output wire [4:0] token,
	output wire own_turn,
	output wire wrap
);
	reg [4:0] token_q;
	reg [9:0] skip_q;
	wire skip_done;
	wire advance;

	assign token = token_q;
	assign own_turn = enable && (token_q == own_addr);
	assign skip_done = (skip_q == `SKIP_CYC - 1);
	// see R13 R15
	assign advance = enable && (own_turn ? own_done :
		((rx_valid && rx_signoff && rx_src == token_q) || skip_done));
	assign wrap = advance && (token_q == 5'h1F);

	always @(posedge clock) begin
		if (srst || !enable) begin
			token_q <= 5'h00;
			skip_q <= 10'h000;
		end else begin
			if (advance) begin
				token_q <= token_q + 5'h01; // see R13
			end
			if (advance || rx_valid || own_turn) begin
				skip_q <= 10'h000;
			end else begin
				skip_q <= skip_q + 10'h001;
			end
		end
	end
endmodule
`default_nettype wire

// ---- token_bus_exchange.v ----
/*
 * token bus data exchange: APB register slave, receive buffer with presence
 * tracking and data defaults, and transmit sequencer for global and output data.
 * assumes the bus framer on the same clock delivers messages as byte streams.
 */
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
`include "token_bus_consts.vh"
module token_bus_exchange #(
	parameter [31:0] MIN_ROT_CYC = `MIN_ROT_CYC
) (
	// clock and reset
	input wire clock,
	input wire srst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// received bytes
	input wire rx_valid,
	input wire [4:0] rx_src,
	input wire [7:0] rx_data,
	input wire rx_last,
	input wire rx_signoff,
	// transmitted bytes
	output reg tx_valid,
	input wire tx_ready,
	output reg [7:0] tx_data,
	output reg [4:0] tx_dst,
	output reg tx_bcast,
	output reg tx_last,
	output reg tx_signoff
);
	localparam ST_IDLE = 3'h0;
	localparam ST_GLOB = 3'h1;
	localparam ST_OUT = 3'h2;
	localparam ST_SIGN = 3'h3;
	localparam ST_DONE = 3'h4;

	reg [31:0] ctrl_q;
	reg [7:0] rx_len_q [0:31];
	reg [7:0] out_len_q [0:31];
	reg [7:0] rx_mem [0:4095];
	reg [7:0] out_mem [0:4095];
	reg [7:0] gtx_mem [0:127];
	reg [31:0] present_q;
	reg [31:0] lost_q;
	reg [31:0] seen_q;
	reg [31:0] got_q;
	reg [31:0] bad_q;
	reg [7:0] rx_idx_q;
	reg [2:0] state_q;
	reg [4:0] dev_q;
	reg [6:0] idx_q;
	reg [31:0] rot_q;
	reg own_done;
	reg [31:0] rd_d;
	reg dec_err;

	wire run = ctrl_q[`CTRL_RUN];
	wire hold = ctrl_q[`CTRL_HOLD];
	wire cfg = ctrl_q[`CTRL_CFG];
	wire [4:0] own = ctrl_q[`CTRL_OWN_HI:`CTRL_OWN_LO];
	wire [7:0] glen = (ctrl_q[`CTRL_GLEN_HI:`CTRL_GLEN_LO] > `BLOCK_MAX) ? `BLOCK_MAX :
		ctrl_q[`CTRL_GLEN_HI:`CTRL_GLEN_LO];
	wire [4:0] token;
	wire own_turn;
	wire wrap;
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire data_wr = pwrite && (paddr[13:12] == `RGN_OUT || paddr[13:12] == `RGN_GTX);
	// see R19
	wire stall = psel && data_wr && (state_q != ST_IDLE);
	wire wr_en = access && pready && pwrite && !dec_err;
	wire slot = !tx_valid || tx_ready;
	wire [4:0] rsrc = paddr[11:7];
	wire [11:0] rbase = {paddr[11:2], 2'b00};
	wire [7:0] cur_len = rx_len_q[rx_src];
	wire rx_take = rx_valid && !rx_signoff && rx_src != own && cur_len != 8'h00;
	wire [31:0] status_vec;

	assign pready = !stall;
	assign pslverr = access && dec_err;

	token_tracker u_tracker (
		.clock(clock),
		.srst(srst),
		.enable(cfg),
		.own_addr(own),
		.rx_valid(rx_valid),
		.rx_signoff(rx_signoff),
		.rx_src(rx_src),
		.own_done(own_done),
		.token(token),
		.own_turn(own_turn),
		.wrap(wrap)
	);

	// presence vector with own bit forced while configured
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_src
			wire set_seen = rx_valid && rx_src == g && rx_len_q[g] != 8'h00;
			wire end_msg = rx_take && rx_last && rx_src == g;
			wire good = end_msg && (rx_idx_q + 8'h01 == rx_len_q[g]);
			// see R5 R6
			assign status_vec[g] = (own == g) ? cfg : present_q[g];
			always @(posedge clock) begin
				if (srst) begin
					present_q[g] <= 1'b0;
					lost_q[g] <= 1'b1;
					seen_q[g] <= 1'b0;
					got_q[g] <= 1'b0;
					bad_q[g] <= 1'b0;
				end else if (wrap) begin
					// see R20 R7 R9
					present_q[g] <= (seen_q[g] || set_seen) && !(bad_q[g] || (end_msg && !good))
						&& rx_len_q[g] != 8'h00;
					lost_q[g] <= !(got_q[g] || good);
					seen_q[g] <= set_seen;
					got_q[g] <= good;
					bad_q[g] <= end_msg && !good;
				end else begin
					// set wins over the end-of-rotation clear; see R14
					if (set_seen) begin
						seen_q[g] <= 1'b1;
					end
					if (good) begin
						got_q[g] <= 1'b1;
						lost_q[g] <= 1'b0;
					end
					if (end_msg && !good) begin
						bad_q[g] <= 1'b1;
					end
					if (rx_len_q[g] == 8'h00) begin
						present_q[g] <= 1'b0; // see R7
						lost_q[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// receive byte store, open at all times
	always @(posedge clock) begin
		if (srst) begin
			rx_idx_q <= 8'h00;
		end else if (rx_valid) begin
			if (rx_last || rx_signoff) begin
				rx_idx_q <= 8'h00;
			end else begin
				rx_idx_q <= rx_idx_q + 8'h01;
			end
		end
	end

	always @(posedge clock) begin
		// see R1 R2 R14 R18
		if (rx_take && rx_idx_q < cur_len && rx_idx_q < `BLOCK_MAX) begin
			rx_mem[{rx_src, rx_idx_q[6:0]}] <= rx_data;
		end
	end

	// register read decode
	always @* begin
		rd_d = 32'h00000000;
		dec_err = 1'b0;
		case (paddr[13:12])
			2'h0: begin
				if (paddr == `OFS_CTRL) begin
					rd_d = ctrl_q;
				end else if (paddr == `OFS_STATUS) begin
					rd_d = status_vec; // see R8 R16
				end else if (paddr == `OFS_TOKEN) begin
					rd_d = {24'h000000, state_q, token};
				end else if (paddr[11:7] == `RGN_LEN && paddr[1:0] == 2'h0) begin
					rd_d = {16'h0000, out_len_q[paddr[6:2]], rx_len_q[paddr[6:2]]};
				end else begin
					dec_err = 1'b1;
				end
			end
			`RGN_RX: begin
				// see R3 R4
				if (!(lost_q[rsrc] && !hold)) begin
					rd_d = {rx_mem[rbase + 12'h003], rx_mem[rbase + 12'h002],
						rx_mem[rbase + 12'h001], rx_mem[rbase]};
				end
			end
			`RGN_OUT: begin
				rd_d = {out_mem[rbase + 12'h003], out_mem[rbase + 12'h002],
					out_mem[rbase + 12'h001], out_mem[rbase]};
			end
			default: begin
				if (paddr[11:7] == 5'h00) begin
					rd_d = {gtx_mem[{paddr[6:2], 2'h3}], gtx_mem[{paddr[6:2], 2'h2}],
						gtx_mem[{paddr[6:2], 2'h1}], gtx_mem[{paddr[6:2], 2'h0}]};
				end else begin
					dec_err = 1'b1;
				end
			end
		endcase
	end

	// register write and read capture
	always @(posedge clock) begin
		if (srst) begin
			ctrl_q <= `CTRL_RESET;
			prdata <= 32'h00000000;
		end else begin
			if (setup && !pwrite) begin
				prdata <= rd_d;
			end
			if (wr_en && paddr == `OFS_CTRL) begin
				ctrl_q <= pwdata;
			end
		end
	end

	generate
		for (g = 0; g < 32; g = g + 1) begin : g_len
			always @(posedge clock) begin
				if (srst) begin
					rx_len_q[g] <= 8'h00;
					out_len_q[g] <= 8'h00;
				end else if (wr_en && paddr == `OFS_LEN_BASE + g * 4) begin
					rx_len_q[g] <= (pwdata[7:0] > `BLOCK_MAX) ? `BLOCK_MAX : pwdata[7:0];
					out_len_q[g] <= (pwdata[15:8] > `BLOCK_MAX) ? `BLOCK_MAX : pwdata[15:8];
				end
			end
		end
	endgenerate

	// data buffers written by the CPU; see R10 R11
	always @(posedge clock) begin
		if (wr_en && paddr[13:12] == `RGN_OUT) begin
			out_mem[rbase] <= pwdata[7:0];
			out_mem[rbase + 12'h001] <= pwdata[15:8];
			out_mem[rbase + 12'h002] <= pwdata[23:16];
			out_mem[rbase + 12'h003] <= pwdata[31:24];
		end
		if (wr_en && paddr[13:12] == `RGN_GTX) begin
			gtx_mem[{paddr[6:2], 2'h0}] <= pwdata[7:0];
			gtx_mem[{paddr[6:2], 2'h1}] <= pwdata[15:8];
			gtx_mem[{paddr[6:2], 2'h2}] <= pwdata[23:16];
			gtx_mem[{paddr[6:2], 2'h3}] <= pwdata[31:24];
		end
	end

	// transmit sequencer, active only on own token turn
	always @(posedge clock) begin
		if (srst) begin
			state_q <= ST_IDLE;
			dev_q <= 5'h00;
			idx_q <= 7'h00;
			rot_q <= 32'h00000000;
			own_done <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_dst <= 5'h00;
			tx_bcast <= 1'b0;
			tx_last <= 1'b0;
			tx_signoff <= 1'b0;
		end else begin
			own_done <= 1'b0;
			if (rot_q != MIN_ROT_CYC) begin
				rot_q <= rot_q + 32'h00000001;
			end
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
			end
			case (state_q)
				ST_IDLE: begin
					dev_q <= 5'h00;
					idx_q <= 7'h00;
					if (own_turn && !own_done) begin
						// see R12
						if (!run) begin
							state_q <= ST_SIGN;
						end else if (glen != 8'h00) begin
							state_q <= ST_GLOB;
						end else begin
							state_q <= ST_OUT;
						end
					end
				end
				ST_GLOB: begin
					if (slot) begin
						// see R11 R18
						tx_valid <= 1'b1;
						tx_data <= gtx_mem[idx_q];
						tx_dst <= 5'h1F;
						tx_bcast <= 1'b1;
						tx_signoff <= 1'b0;
						tx_last <= ({1'b0, idx_q} == glen - 8'h01);
						idx_q <= idx_q + 7'h01;
						if ({1'b0, idx_q} == glen - 8'h01) begin
							idx_q <= 7'h00;
							state_q <= ST_OUT;
						end
					end
				end
				ST_OUT: begin
					// see R10
					if (dev_q == own || out_len_q[dev_q] == 8'h00) begin
						dev_q <= dev_q + 5'h01;
						if (dev_q == 5'h1F) begin
							state_q <= ST_SIGN;
						end
					end else if (slot) begin
						tx_valid <= 1'b1;
						tx_data <= out_mem[{dev_q, idx_q}];
						tx_dst <= dev_q;
						tx_bcast <= 1'b0;
						tx_signoff <= 1'b0;
						tx_last <= ({1'b0, idx_q} == out_len_q[dev_q] - 8'h01);
						idx_q <= idx_q + 7'h01;
						if ({1'b0, idx_q} == out_len_q[dev_q] - 8'h01) begin
							idx_q <= 7'h00;
							dev_q <= dev_q + 5'h01;
							if (dev_q == 5'h1F) begin
								state_q <= ST_SIGN;
							end
						end
					end
				end
				ST_SIGN: begin
					// see R15 R17
					if (slot && rot_q == MIN_ROT_CYC) begin
						tx_valid <= 1'b1;
						tx_data <= 8'h00;
						tx_dst <= 5'h1F;
						tx_bcast <= 1'b1;
						tx_last <= 1'b1;
						tx_signoff <= 1'b1;
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (tx_valid && tx_ready) begin
						own_done <= 1'b1;
						rot_q <= 32'h00000000;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- token_bus_exchange_sva.sv ----
/* checker for token_bus_exchange: apb and transmit handshake relations.
   assumes it is bound to the top module and sees its ports only. */
`default_nettype none
module token_bus_exchange_sva #(parameter [31:0] MIN_ROT_CYC = 75000) (
	// clock and reset
	input wire logic clock, srst,
	// apb
	input wire logic psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	// transmit
	input wire logic tx_valid, tx_ready, tx_bcast, tx_last, tx_signoff,
	input wire logic [4:0] tx_dst,
	input wire logic [7:0] tx_data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error response outside access phase");
	a_idle_ready: assert property (!psel |-> pready)
		else $error("ready low while idle");
	a_stall_write: assert property (psel && penable && !pready |-> pwrite)
		else $error("read was stalled");
	a_stall_bound: assert property (psel && penable && !pready |-> ##[1:1000] pready)
		else $error("write stall too long");
	a_read_stands: assert property (psel && penable && pready && !pwrite |=> $stable(prdata))
		else $error("read data changed");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable({tx_data, tx_dst, tx_bcast, tx_last, tx_signoff}))
		else $error("tx byte not held");
	a_signoff_form: assert property (tx_valid && tx_signoff |-> tx_bcast && tx_last
		&& tx_data == 8'h00)
		else $error("bad sign-off");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !tx_valid && prdata == 32'h0)
		else $error("not quiet after reset");
	c_signoff: cover property (tx_valid && tx_ready && tx_signoff);
	c_stall: cover property (tx_valid && !tx_ready);
	c_slverr: cover property (pslverr);
endmodule
bind token_bus_exchange token_bus_exchange_sva #(.MIN_ROT_CYC(MIN_ROT_CYC)) u_sva (.clock, .srst,
	.psel, .penable, .pwrite, .pready, .pslverr, .prdata, .tx_valid, .tx_ready, .tx_bcast,
	.tx_last, .tx_signoff, .tx_dst, .tx_data);
`default_nettype wire

// ---- bus_station_model.sv ----
/* model of the other bus stations: sends data and sign-offs, sinks tx bytes.
   assumes the dut sits at address 20 and its token starts at 0. */
`default_nettype none
module bus_station_model (
	// clock
	input wire logic clock,
	// events to dut
	output var logic rx_valid, rx_last, rx_signoff,
	output var logic [4:0] rx_src,
	output var logic [7:0] rx_data,
	// bytes from dut
	input wire logic tx_valid, tx_bcast, tx_signoff,
	input wire logic [4:0] tx_dst,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [14:0] seen_q[$];
	logic [1:0] cnt = 2'h0;
	initial {rx_valid, rx_last, rx_signoff, rx_src, rx_data} = 16'h0;
	// slow sink, stalls one cycle in four
	assign tx_ready = cnt != 2'h3;
	always @(posedge clock) begin
		cnt <= cnt + 2'h1;
		if (tx_valid && tx_ready)
			seen_q.push_back({tx_bcast, tx_signoff, tx_dst, tx_data});
	end
	task automatic ev(input logic [4:0] s, input logic [7:0] d, input logic l, so);
		rx_valid <= 1'b1;
		{rx_src, rx_data, rx_last, rx_signoff} <= {s, d, l, so};
		@(posedge clock);
	endtask
	task automatic idle();
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
	// one rotation; n5 bytes from station 5, negative keeps it silent
	task automatic rotate(input int n5);
		int k;
		seen_q.delete();
		for (int a = 0; a < 32; a++) begin
			if (a == 20) begin
				idle();
				k = 0;
				while (k < 3000 && !(seen_q.size() > 0 && seen_q[$][13])) begin
					@(posedge clock);
					k++;
				end
				// token moves on one edge after the sign-off
				@(posedge clock);
			end else if (a == 5 && n5 < 0) begin
				idle();
				repeat (700) @(posedge clock);
			end else begin
				for (int i = 0; i < n5 && a == 5; i++)
					ev(5'd5, 8'h11 * (i + 1), i == n5 - 1, 1'b0);
				ev(a[4:0], 8'h00, 1'b0, 1'b1);
			end
		end
		idle();
		repeat (2) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ---- token_bus_exchange_tb.sv ----
/* bench for token_bus_exchange: apb tasks and token rotations.
   assumes the station model drives the bus side. */
`default_nettype none
module token_bus_exchange_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, rx_valid, rx_last, rx_signoff, tx_ready;
	logic tx_valid, tx_bcast, tx_last, tx_signoff;
	logic [4:0] rx_src, tx_dst;
	logic [7:0] rx_data, tx_data;
	logic [14:0] exp_tx [7] = '{15'h4001, 15'h4002, 15'h4003, 15'h4004, 15'h07EF,
		15'h07BE, 15'h6000};
	int err_total = 0, n_tests = 0;
	int n_last = 0;
	always #20 clock = ~clock;
	always @(posedge clock) begin
		if (tx_valid && tx_ready && tx_last)
			n_last <= n_last + 1;
	end
	token_bus_exchange #(.MIN_ROT_CYC(200)) u_dut (.clock, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_src, .rx_data, .rx_last,
		.rx_signoff, .tx_valid, .tx_ready, .tx_data, .tx_dst, .tx_bcast, .tx_last, .tx_signoff);
	bus_station_model u_peer (.clock, .rx_valid, .rx_last, .rx_signoff, .rx_src, .rx_data,
		.tx_valid, .tx_bcast, .tx_signoff, .tx_dst, .tx_data, .tx_ready);
	task automatic check(input string w, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		{pwrite, paddr, pwdata} <= {wr, a, d};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string w, input logic [13:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(w, rd, x);
	endtask
	function automatic logic [14:0] tx_at(input int i);
		return u_peer.seen_q[i] & (u_peer.seen_q[i][14] ? 15'h60FF : 15'h7FFF);
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rd_chk("ctrl", 14'h0000, 32'h0);
		rd_chk("status", 14'h0004, 32'h0);
		apb(1'b0, 14'h0040, 32'h0);
		check("slverr", {31'h0, e}, 32'h1);
		apb(1'b1, 14'h0114, 32'h00000004);
		apb(1'b1, 14'h011C, 32'h00000200);
		apb(1'b1, 14'h2380, 32'h0000BEEF);
		apb(1'b1, 14'h3000, 32'hA1B2C3D4);
		apb(1'b1, 14'h3000, 32'h04030201);
		apb(1'b1, 14'h0000, 32'h00041405);
		rd_chk("own bit", 14'h0004, 32'h00100000);
		$display("test setup done");
		u_peer.rotate(4);
		rd_chk("status", 14'h0004, 32'h00100020);
		rd_chk("rx data", 14'h1280, 32'h44332211);
		check("tx count", u_peer.seen_q.size(), 32'd7);
		check("tx last", n_last, 32'd3);
		foreach (exp_tx[i]) check("tx byte", tx_at(i), exp_tx[i]);
		$display("test exchange done");
		apb(1'b1, 14'h0000, 32'h00041404);
		u_peer.rotate(-1);
		check("tx stop", u_peer.seen_q.size(), 32'd1);
		check("tx signoff", tx_at(0), 15'h6000);
		rd_chk("lost bit", 14'h0004, 32'h00100000);
		rd_chk("off data", 14'h1280, 32'h0);
		apb(1'b1, 14'h0000, 32'h00041406);
		rd_chk("hold data", 14'h1280, 32'h44332211);
		apb(1'b1, 14'h0000, 32'h00041404);
		$display("test default done");
		u_peer.rotate(0);
		rd_chk("stop bit", 14'h0004, 32'h00100020);
		rd_chk("stop data", 14'h1280, 32'h0);
		fork
			u_peer.rotate(3);
			begin
				do begin
					apb(1'b0, 14'h0008, 32'h0);
				end while (rd[7:5] == 3'h0);
				check("token", {27'h0, rd[4:0]}, 32'd20);
				apb(1'b1, 14'h3000, 32'h0A0B0C0D);
				check("stall order", u_peer.seen_q.size(), 32'd1);
			end
		join
		rd_chk("gtx data", 14'h3000, 32'h0A0B0C0D);
		rd_chk("bad length", 14'h0004, 32'h00100000);
		$display("test status done");
		print_verdict();
	end
endmodule
`default_nettype wire
